// ### verilog/spc_pkg.sv
// constants and types for the serial port core
package spc_pkg;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0000;
	localparam logic [31:0] ADDR_CONTROL = 32'h0000_0004;
	localparam logic [31:0] ADDR_DATA = 32'h0000_0008;
	localparam logic [31:0] ADDR_FLAG = 32'h0000_000c;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ST_SAMPLE = 7;
	localparam int ST_EDGE = 6;
	localparam int ST_STOP = 4;
	localparam int ST_FULL = 0;
	localparam int CT_WRITE_COLLISION = 7;
	localparam int CT_OVF = 6;
	localparam int CT_EN = 5;
	localparam int CT_POL = 4;
	localparam int FL_PIF = 0;

	// ------------------------------------------------------------
	// modes and timing
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_MASTER_DIV4 = 4'h0,
		MODE_MASTER_DIV16 = 4'h1,
		MODE_MASTER_DIV64 = 4'h2,
		MODE_MASTER_TIMER = 4'h3,
		MODE_SLAVE_SEL = 4'h4,
		MODE_SLAVE_FREE = 4'h5
	} spc_mode_e;

	localparam logic [5:0] HALF_DIV4 = 6'h02;
	localparam logic [5:0] HALF_DIV16 = 6'h08;
	localparam logic [5:0] HALF_DIV64 = 6'h20;
	localparam logic [4:0] LAST_HALF = 5'h10;
	localparam logic [4:0] SCK_TOGGLES = 5'h10;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// whole state of the core
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] data_buffer;
		logic [7:0] shift_register;
		logic serial_out_pin;
		logic sdo_oe;
		logic sck;
		logic sck_oe;
		logic sck_prev;
		logic sample;
		logic active;
		logic pins_taken;
		logic [4:0] half_cnt;
		logic [5:0] div_cnt;
		logic [3:0] bit_cnt;
		logic sample_phase;
		logic clock_edge;
		logic stop;
		logic buffer_full;
		logic write_collision;
		logic receive_overflow;
		logic port_enable;
		logic clock_polarity;
		logic [3:0] mode_field;
		logic port_interrupt_flag;
		logic aw_got;
		logic [31:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} spc_state_s;

endpackage

// ### verilog/spc_top.sv
// byte-wide spi serial port core with axi4-lite register access
//
// How it works
// - every transfer moves 8 bits out and 8 bits in together
// - bytes are shifted most significant bit first
// - full byte goes to data buffer, sets buffer_full and interrupt flag
// - data buffer write loads buffer and shift register at once
// - data write during shifting is dropped, sets sticky write_collision
// - slave byte arriving on unread buffer sets receive_overflow, old byte kept
// - master mode never sets receive_overflow
// - master transfers start only on a data buffer write
// - buffer_full set on reception, cleared by reading the data buffer
// - master sample_phase: 1 samples at end, 0 at middle of bit
// - clock edge bit 1 shifts on active-to-idle, 0 on idle-to-active
// - clock_polarity gives the idle serial clock level
// - modes 0 to 3 select master at clock/4, /16, /64, timer_two/2
// - mode 4 slave with select gating, mode 5 slave without
// - port_enable hands the pins to the port, else general purpose
// - stop bit clears whenever port_enable is clear
// - status low six bits read only, top two read and write
// - shift register reachable only through the data buffer
// - select high in mode 4 floats serial out and zeroes bit count
`timescale 1ns/10ps

module spc_top
	import spc_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// axi4-lite write
	input wire logic [31:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// axi4-lite read
	input wire logic [31:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// serial pins
	input wire logic SCK_I,
	output logic SCK_O,
	output logic SCK_OE,
	input wire logic SDI_I,
	output logic SDO_O,
	output logic SDO_OE,
	input wire logic SS_N_I,
	// rate source and status
	input wire logic TIMER_TWO_TICK,
	output logic PINS_TAKEN,
	output logic PORT_INTERRUPT_FLAG
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic is_master(input logic [3:0] m);
		is_master = (m == MODE_MASTER_DIV4) || (m == MODE_MASTER_DIV16) ||
			(m == MODE_MASTER_DIV64) || (m == MODE_MASTER_TIMER);
	endfunction

	function automatic logic is_slave(input logic [3:0] m);
		is_slave = (m == MODE_SLAVE_SEL) || (m == MODE_SLAVE_FREE);
	endfunction

	// received byte lands in the buffer, or is lost on overflow
	function automatic spc_state_s finish_byte(input spc_state_s st, input logic [7:0] b);
		finish_byte = st;
		if (st.buffer_full && is_slave(st.mode_field)) begin
			finish_byte.receive_overflow = 1'b1;
		end else begin
			finish_byte.data_buffer = b;
			finish_byte.buffer_full = 1'b1;
			finish_byte.port_interrupt_flag = 1'b1;
		end
	endfunction

	function automatic logic [7:0] status_byte(input spc_state_s st);
		status_byte = 8'h00;
		status_byte[ST_SAMPLE] = st.sample_phase;
		status_byte[ST_EDGE] = st.clock_edge;
		status_byte[ST_STOP] = st.stop;
		status_byte[ST_FULL] = st.buffer_full;
	endfunction

	function automatic logic [7:0] control_byte(input spc_state_s st);
		control_byte = {st.write_collision, st.receive_overflow, st.port_enable,
			st.clock_polarity, st.mode_field};
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	spc_state_s s_q;
	spc_state_s s_d;
	logic wr_fire;
	logic busy;
	logic master;
	logic ss_gate;
	logic half_tick;
	logic lead_edge;
	logic trail_edge;
	logic [4:0] hc;
	logic [4:0] rel;
	logic [7:0] shifted;
	logic in_bit;

	always_comb begin
		s_d = s_q;
		wr_fire = 1'b0;
		half_tick = 1'b0;
		hc = s_q.half_cnt;
		rel = s_q.half_cnt;
		shifted = s_q.shift_register;
		in_bit = SDI_I;
		master = s_q.port_enable && is_master(s_q.mode_field);
		ss_gate = (s_q.mode_field == MODE_SLAVE_SEL) && SS_N_I;
		busy = master ? s_q.active : (s_q.bit_cnt != 4'h0);
		lead_edge = (s_q.sck_prev == s_q.clock_polarity) && (SCK_I != s_q.clock_polarity);
		trail_edge = (s_q.sck_prev != s_q.clock_polarity) && (SCK_I == s_q.clock_polarity);

		// ------------------------------------------------------------
		// register write path
		// ------------------------------------------------------------
		if (AWVALID && s_q.awready) begin
			s_d.aw_got = 1'b1;
			s_d.aw_addr = AWADDR;
		end
		if (WVALID && s_q.wready) begin
			s_d.w_got = 1'b1;
			s_d.w_data = WDATA;
			s_d.w_strb = WSTRB;
		end
		if (s_q.bvalid && BREADY) begin
			s_d.bvalid = 1'b0;
		end
		wr_fire = s_d.aw_got && s_d.w_got && !s_q.bvalid;
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			case (s_d.aw_addr)
				ADDR_STATUS: begin
					if (s_d.w_strb[0]) begin
						s_d.sample_phase = s_d.w_data[ST_SAMPLE];
						s_d.clock_edge = s_d.w_data[ST_EDGE];
					end
				end
				ADDR_CONTROL: begin
					if (s_d.w_strb[0]) begin
						s_d.write_collision = s_d.w_data[CT_WRITE_COLLISION];
						s_d.receive_overflow = s_d.w_data[CT_OVF];
						s_d.port_enable = s_d.w_data[CT_EN];
						s_d.clock_polarity = s_d.w_data[CT_POL];
						s_d.mode_field = s_d.w_data[3:0];
					end
				end
				ADDR_DATA: begin
					if (s_d.w_strb[0]) begin
						if (busy) begin
							s_d.write_collision = 1'b1;
						end else begin
							s_d.data_buffer = s_d.w_data[7:0];
							s_d.shift_register = s_d.w_data[7:0];
							s_d.serial_out_pin = s_d.w_data[7];
							if (master) begin
								s_d.active = 1'b1;
								s_d.half_cnt = 5'h00;
								s_d.div_cnt = 6'h00;
							end
						end
					end
				end
				ADDR_FLAG: begin
					if (s_d.w_strb[0] && s_d.w_data[FL_PIF]) begin
						s_d.port_interrupt_flag = 1'b0;
					end
				end
				default: begin
					s_d.bresp = RESP_SLVERR;
				end
			endcase
		end
		s_d.awready = !s_d.aw_got && !s_d.bvalid;
		s_d.wready = !s_d.w_got && !s_d.bvalid;

		// ------------------------------------------------------------
		// register read path
		// ------------------------------------------------------------
		if (s_q.rvalid && RREADY) begin
			s_d.rvalid = 1'b0;
		end
		if (ARVALID && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			case (ARADDR)
				ADDR_STATUS: s_d.rdata = {24'h000000, status_byte(s_q)};
				ADDR_CONTROL: s_d.rdata = {24'h000000, control_byte(s_q)};
				ADDR_DATA: begin
					s_d.rdata = {24'h000000, s_q.data_buffer};
					s_d.buffer_full = 1'b0;
				end
				ADDR_FLAG: s_d.rdata = {31'h00000000, s_q.port_interrupt_flag};
				default: begin
					s_d.rdata = 32'h0000_0000;
					s_d.rresp = RESP_SLVERR;
				end
			endcase
		end
		s_d.arready = !s_d.rvalid;

		// ------------------------------------------------------------
		// master engine
		// ------------------------------------------------------------
		// bit rate sources
		case (s_q.mode_field)
			MODE_MASTER_DIV4: half_tick = (s_q.div_cnt + 6'h01) == HALF_DIV4;
			MODE_MASTER_DIV16: half_tick = (s_q.div_cnt + 6'h01) == HALF_DIV16;
			MODE_MASTER_DIV64: half_tick = (s_q.div_cnt + 6'h01) == HALF_DIV64;
			MODE_MASTER_TIMER: half_tick = TIMER_TWO_TICK;
			default: half_tick = 1'b0;
		endcase
		if (master && s_q.active) begin
			s_d.div_cnt = half_tick ? 6'h00 : s_q.div_cnt + 6'h01;
			if (half_tick) begin
				hc = s_q.half_cnt + 5'h01;
				s_d.half_cnt = hc;
				// edge 0 adds a lead half
				rel = s_q.clock_edge ? hc : hc - 5'h01;
				if (hc <= SCK_TOGGLES) begin
					s_d.sck = !s_q.sck;
				end
				if (rel[0]) begin
					s_d.sample = SDI_I;
				end else if (rel != 5'h00) begin
					in_bit = s_q.sample_phase ? SDI_I : s_q.sample;
					shifted = {s_d.shift_register[6:0], in_bit};
					s_d.shift_register = shifted;
					s_d.serial_out_pin = shifted[7];
					s_d.bit_cnt = s_q.bit_cnt + 4'h1;
					if (rel == LAST_HALF) begin
						s_d = finish_byte(s_d, shifted);
						s_d.active = 1'b0;
						s_d.bit_cnt = 4'h0;
					end
				end
			end
		end else if (master) begin
			s_d.sck = s_q.clock_polarity;
		end

		// ------------------------------------------------------------
		// slave engine, clock pin sampled on the system clock
		// ------------------------------------------------------------
		s_d.sck_prev = SCK_I;
		if (s_q.port_enable && is_slave(s_q.mode_field)) begin
			if (ss_gate) begin
				s_d.bit_cnt = 4'h0;
			end else begin
				if (s_q.clock_edge ? trail_edge : lead_edge) begin
					s_d.serial_out_pin = s_d.shift_register[7];
				end
				if (s_q.clock_edge ? lead_edge : trail_edge) begin
					shifted = {s_d.shift_register[6:0], SDI_I};
					s_d.shift_register = shifted;
					s_d.bit_cnt = s_q.bit_cnt + 4'h1;
					if (s_q.bit_cnt == LAST_BIT) begin
						s_d = finish_byte(s_d, shifted);
						s_d.bit_cnt = 4'h0;
					end
				end
			end
		end

		// ------------------------------------------------------------
		// enable and pin ownership
		// ------------------------------------------------------------
		if (!s_d.port_enable) begin
			s_d.stop = 1'b0;
			s_d.active = 1'b0;
			s_d.bit_cnt = 4'h0;
			s_d.half_cnt = 5'h00;
			s_d.div_cnt = 6'h00;
		end
		// idle level, no stray edge on enable
		if (!s_d.active) begin
			s_d.sck = s_d.clock_polarity;
		end
		s_d.pins_taken = s_d.port_enable;
		s_d.sck_oe = s_d.port_enable && is_master(s_d.mode_field);
		s_d.sdo_oe = s_d.port_enable && (is_master(s_d.mode_field) ||
			(s_d.mode_field == MODE_SLAVE_FREE) ||
			((s_d.mode_field == MODE_SLAVE_SEL) && !SS_N_I));
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// outputs, all from the state flops
	// ------------------------------------------------------------
	assign AWREADY = s_q.awready;
	assign WREADY = s_q.wready;
	assign BVALID = s_q.bvalid;
	assign BRESP = s_q.bresp;
	assign ARREADY = s_q.arready;
	assign RVALID = s_q.rvalid;
	assign RDATA = s_q.rdata;
	assign RRESP = s_q.rresp;
	assign SCK_O = s_q.sck;
	assign SCK_OE = s_q.sck_oe;
	assign SDO_O = s_q.serial_out_pin;
	assign SDO_OE = s_q.sdo_oe;
	assign PINS_TAKEN = s_q.pins_taken;
	assign PORT_INTERRUPT_FLAG = s_q.port_interrupt_flag;

endmodule

// ### verif/spc_top_properties.sv
// port assertions for the serial port core
`timescale 1ns/10ps
module spc_top_properties
	import spc_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// register bus
	input wire logic [31:0] AWADDR,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic [31:0] ARADDR,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic RVALID,
	// serial pins and status
	input wire logic SCK_O,
	input wire logic SCK_OE,
	input wire logic SDO_OE,
	input wire logic SS_N_I,
	input wire logic PINS_TAKEN,
	input wire logic PORT_INTERRUPT_FLAG
);
	logic [31:0] aw_q, ar_q;
	logic [7:0] w_q, ctl_q;
	logic [4:0] tog_q;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);
	// shadow lags the core by a cycle, so checks skip the write answer
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			{aw_q, ar_q, w_q, ctl_q, tog_q} <= '0;
		end else begin
			if (AWVALID && AWREADY) aw_q <= AWADDR;
			if (WVALID && WREADY) w_q <= WDATA[7:0];
			if (ARVALID && ARREADY) ar_q <= ARADDR;
			if (BVALID && BREADY && aw_q == ADDR_CONTROL) ctl_q <= w_q;
			if (!SCK_OE || !$past(SCK_OE) || $rose(PORT_INTERRUPT_FLAG)) tog_q <= '0;
			else if ($changed(SCK_O)) tog_q <= tog_q + 5'h1;
		end
	end
	chk_byte_len: assert property (
		$rose(PORT_INTERRUPT_FLAG) && SCK_OE
		|-> tog_q + 5'(SCK_O != $past(SCK_O)) == 5'h10)
		else $error("clock toggle count wrong at byte end");
	chk_pins_taken: assert property (
		!BVALID && !$past(BVALID) |-> PINS_TAKEN == ctl_q[CT_EN])
		else $error("pin ownership differs from enable");
	chk_idle_level: assert property (
		!BVALID && !$past(BVALID) && !ctl_q[CT_EN] |-> SCK_O == ctl_q[CT_POL])
		else $error("idle clock level wrong");
	chk_master_clk: assert property (
		!BVALID && !$past(BVALID)
		|-> SCK_OE == (ctl_q[CT_EN] && ctl_q[3:0] < 4'h4))
		else $error("clock drive differs from mode");
	chk_ss_release: assert property (
		ctl_q[CT_EN] && ctl_q[3:0] == 4'h4 && SS_N_I ##1 SS_N_I |-> !SDO_OE)
		else $error("data out driven while deselected");
	chk_no_ovf: assert property (
		RVALID && ar_q == ADDR_CONTROL && ctl_q[3:0] < 4'h4 |-> !RDATA[CT_OVF])
		else $error("overflow seen in master mode");
	chk_status_ro: assert property (
		RVALID && ar_q == ADDR_STATUS |-> RDATA[31:8] == 24'h0 && RDATA[3:1] == 3'h0)
		else $error("status unused bits not zero");
	chk_stop_clear: assert property (
		RVALID && ar_q == ADDR_STATUS |-> !RDATA[ST_STOP] && !RDATA[5])
		else $error("stop bit set");
endmodule
bind spc_top spc_top_properties spc_top_properties_i (.*);

// ### verif/spc_link_partner.sv
// far-side spi slave answering the core in master mode
`timescale 1ns/10ps
module spc_link_partner (
	// serial lines
	input wire logic sck,
	input wire logic sck_oe,
	input wire logic serial_out_pin,
	output logic serial_in_pin,
	// frame setup
	input wire logic cpol,
	input wire logic cke
);
	logic [7:0] sh = 8'h0;
	logic [7:0] rx;
	int n;
	task automatic start(input logic [7:0] b);
		sh = b;
		n = 0;
	endtask
	assign serial_in_pin = sh[7];
	always @(sck) begin
		if (sck_oe && n < 16) begin
			n++;
			if ((sck != cpol) == cke) begin
				rx = {rx[6:0], serial_out_pin};
			end else if (cke || n > 1) begin
				sh = sh << 1;
			end
			// edge 1 releases after its last shift, edge 0 holds bit 0 for the late sample
			if (n == 16 && cke) sh = {8{~sh[7]}};
		end
	end
endmodule

// ### verif/test_spi_serial_port_core.sv
// self-checking bench for the serial port core
`timescale 1ns/10ps
module test_spi_serial_port_core;
	import spc_pkg::*;
	logic CLOCK, RST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID;
	logic ARREADY, RVALID, RREADY, SCK_I, SCK_O, SCK_OE, SDI_I, SDO_O, SDO_OE, SS_N_I;
	logic TIMER_TWO_TICK, PINS_TAKEN, PORT_INTERRUPT_FLAG, b_sdi, p_sdi, slv, cpol, cke;
	logic [31:0] AWADDR, WDATA, ARADDR, RDATA, rnd, d;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP, tk, r;
	logic [7:0] got;
	int n_fail, tests_run, wt, q[$];
	int hs[4] = '{2, 8, 32, 4};
	assign SDI_I = slv ? b_sdi : p_sdi;
	spc_top spc_top_i (.*);
	spc_link_partner spc_link_partner_i (
		.sck(SCK_O),
		.sck_oe(SCK_OE),
		.serial_out_pin(SDO_O),
		.serial_in_pin(p_sdi),
		.cpol(cpol),
		.cke(cke)
	);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] v);
		@(posedge CLOCK);
		AWADDR <= a;
		WDATA <= {24'h0, v};
		{AWVALID, WVALID, BREADY} <= 3'h7;
		do begin
			@(posedge CLOCK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
		end while (BVALID !== 1'b1);
		r = BRESP;
		BREADY <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(posedge CLOCK);
		ARADDR <= a;
		{ARVALID, RREADY} <= 2'h3;
		do begin
			@(posedge CLOCK);
			if (ARREADY) ARVALID <= 1'b0;
		end while (RVALID !== 1'b1);
		d = RDATA;
		r = RRESP;
		RREADY <= 1'b0;
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		rd(a);
		chk($sformatf("reg %h", a), e, d);
	endtask
	// slave frames: clock held low outside, data inverted after
	task automatic sbyte(input logic [7:0] b, input int nb);
		for (int k = 0; k < nb; k++) begin
			@(posedge CLOCK);
			b_sdi <= b[7 - k];
			repeat (3) @(posedge CLOCK);
			got[7 - k] = SDO_O;
			SCK_I <= 1'b1;
			repeat (4) @(posedge CLOCK);
			SCK_I <= 1'b0;
		end
		@(posedge CLOCK);
		b_sdi <= ~b_sdi;
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		CLOCK = 1'b0;
		forever #25 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		if (!RST_N) begin
			tk <= 2'h0;
			TIMER_TWO_TICK <= 1'b0;
		end else begin
			tk <= tk + 2'h1;
			TIMER_TWO_TICK <= tk == 2'h3;
		end
	end
	initial begin
		repeat (20000) @(posedge CLOCK);
		n_fail++;
		wrap_up();
	end
	initial begin
		{RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, SCK_I, b_sdi, slv} = '0;
		{AWADDR, WDATA, ARADDR, cpol, cke} = '0;
		SS_N_I = 1'b1;
		WSTRB = 4'h1;
		rnd = 32'h4719d101;
		repeat (6) @(posedge CLOCK);
		RST_N <= 1'b1;
		rdc(ADDR_STATUS, 32'h0);
		rdc(ADDR_CONTROL, 32'h0);
		rd(32'h10);
		chk("resp", RESP_SLVERR, r);
		chk("bad", 32'h0, d);
		wr(ADDR_STATUS, 8'hff);
		chk("wresp", RESP_OKAY, r);
		wr(32'h10, 8'h55);
		chk("bad wresp", RESP_SLVERR, r);
		rdc(ADDR_STATUS, 32'hc0);
		// --------
		// master transfers, every mode and clock shape
		// --------
		for (int i = 0; i < 8; i++) begin
			cpol = i[2];
			cke = i[0] ^ i[2];
			wr(ADDR_CONTROL, 8'h0);
			wr(ADDR_STATUS, {i[1], cke, 6'h0});
			wr(ADDR_CONTROL, {3'h1, cpol, 2'h0, i[1:0]});
			repeat (2) @(negedge CLOCK);
			chk("pins", 32'h1, PINS_TAKEN);
			chk("idle", cpol, SCK_O);
			rnd = lfsr(rnd);
			spc_link_partner_i.start(rnd[15:8]);
			q.push_back(int'(rnd[15:8]));
			wr(ADDR_DATA, rnd[7:0]);
			wr(ADDR_DATA, ~rnd[7:0]);
			for (wt = 0; wt < 3000 && PORT_INTERRUPT_FLAG !== 1'b1; wt++) @(posedge CLOCK);
			chk("rate", 32'h1, wt >= 14 * hs[i % 4] && wt <= 18 * hs[i % 4]);
			chk("rx", rnd[7:0], spc_link_partner_i.rx);
			rdc(ADDR_FLAG, 32'h1);
			rdc(ADDR_STATUS, {i[1], cke, 6'h1});
			rdc(ADDR_DATA, q.pop_front());
			rdc(ADDR_STATUS, {i[1], cke, 6'h0});
			rdc(ADDR_CONTROL, {3'h5, cpol, 2'h0, i[1:0]});
			wr(ADDR_FLAG, 8'h1);
			@(negedge CLOCK);
			chk("flag", 32'h0, PORT_INTERRUPT_FLAG);
			chk("rest", cpol, SCK_O);
		end
		// master overwrites an unread buffer and never flags overflow
		rnd = lfsr(rnd);
		for (int j = 0; j < 2; j++) begin
			spc_link_partner_i.start(j == 0 ? rnd[7:0] : rnd[15:8]);
			wr(ADDR_FLAG, 8'h1);
			wr(ADDR_DATA, j == 0 ? rnd[23:16] : rnd[31:24]);
			for (wt = 0; wt < 3000 && PORT_INTERRUPT_FLAG !== 1'b1; wt++) @(posedge CLOCK);
		end
		rdc(ADDR_CONTROL, 32'hb3);
		rdc(ADDR_DATA, rnd[15:8]);
		wr(ADDR_CONTROL, 8'h0);
		slv <= 1'b1;
		wr(ADDR_STATUS, 8'h40);
		wr(ADDR_CONTROL, 8'h25);
		rnd = lfsr(rnd);
		wr(ADDR_DATA, rnd[7:0]);
		sbyte(rnd[15:8], 8);
		chk("sdo", rnd[7:0], got);
		sbyte(rnd[23:16], 8);
		rdc(ADDR_CONTROL, 32'h65);
		rdc(ADDR_DATA, rnd[15:8]);
		wr(ADDR_CONTROL, 8'h0);
		wr(ADDR_CONTROL, 8'h24);
		repeat (3) @(negedge CLOCK);
		chk("float", 32'h0, SDO_OE);
		@(posedge CLOCK);
		SS_N_I <= 1'b0;
		sbyte(8'h0f, 4);
		SS_N_I <= 1'b1;
		repeat (2) @(posedge CLOCK);
		SS_N_I <= 1'b0;
		sbyte(rnd[31:24], 8);
		rdc(ADDR_DATA, rnd[31:24]);
		rdc(ADDR_CONTROL, 32'h24);
		wrap_up();
	end
endmodule
